// File: rtl/caption_line_extractor.v
// Behaviour
// RULE_01 - Two straps select one of four modes
// RULE_02 - Modes 1,2: even field line 21
// RULE_03 - Mode 1 locks to separated sync
// RULE_04 - Mode 2 reference: oscillator divided by 32
// RULE_05 - Mode 3: both fields, external sync
// RULE_06 - Mode 4: line 22, both fields
// RULE_07 - Line pulse at caption line per mode
// RULE_08 - Parity output, oscillator output in mode 2
// RULE_09 - Sync pin role changes by mode
// RULE_10 - Caption data open-drain, pulls low only
// RULE_11 - Decoder supplies transfer clock and select
// RULE_12 - No transfer clock generated internally
// RULE_13 - Prefer mode 2 for scrambled cable
// RULE_14 - Decoder samples parity at pulse fall
// RULE_15 - Decoder polls twice per frame
// RULE_16 - Deselected: output released, clocks ignored
`timescale 1ns/100ps
`include "caption_map.vh"

module caption_line_extractor #(
  parameter DATA_W = 16,
  parameter CNT_W = 12
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire MODE_STRAP_LOW,
  input wire MODE_STRAP_HIGH,
  input wire COMPOSITE_VIDEO_IN,
  input wire HORIZ_SYNC_OR_OSC_IN,
  output reg HORIZ_SYNC_OUT,
  output reg HORIZ_SYNC_OE,
  output reg LINE_PULSE_OUT,
  output reg FIELD_PARITY_OUT,
  input wire TRANSFER_CLOCK_IN,
  input wire CHIP_SELECT_N,
  output reg CAPTION_BIT_OUT,
  output reg CAPTION_BIT_OE
);

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  // Counts cut to the counter width on purpose; defaults fit with room
  localparam [31:0] FIRST_BIT_W = `FIRST_BIT_CYC;
  localparam [31:0] BIT_PERIOD_W = `BIT_PERIOD_CYC;
  localparam [CNT_W-1:0] FIRST_BIT_C = FIRST_BIT_W[CNT_W-1:0];
  localparam [CNT_W-1:0] BIT_PERIOD_C = BIT_PERIOD_W[CNT_W-1:0];

  // Falling edge from the delayed and the current synchronised level
  function falls;
    input prev_level;
    input now_level;
    falls = prev_level && !now_level;
  endfunction

  // Rising edge, the mirror of falls
  function rises;
    input prev_level;
    input now_level;
    rises = !prev_level && now_level;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [1:0] strap_lo_s, strap_hi_s, video_s, hpin_s, sck_s, cs_s;
  reg hpin_d, sck_d, video_d;
  reg [1:0] mode_reg;

  always @(posedge SYS_CLK) begin
    strap_lo_s <= {strap_lo_s[0], MODE_STRAP_LOW};
    strap_hi_s <= {strap_hi_s[0], MODE_STRAP_HIGH};
    video_s <= {video_s[0], COMPOSITE_VIDEO_IN};
    hpin_s <= {hpin_s[0], HORIZ_SYNC_OR_OSC_IN};
    sck_s <= {sck_s[0], TRANSFER_CLOCK_IN};
    cs_s <= {cs_s[0], CHIP_SELECT_N};
    hpin_d <= hpin_s[1];
    sck_d <= sck_s[1];
    video_d <= video_s[1];
  end

  // Straps are read continuously; a change takes effect three clocks later
  always @(posedge SYS_CLK) begin
    if (!RESET_N)
      mode_reg <= `MODE_1;
    else
      mode_reg <= {strap_hi_s[1], strap_lo_s[1]}; // RULE_01
  end

  wire mode_osc = (mode_reg == `MODE_2);
  wire mode_even_only = (mode_reg == `MODE_1) || mode_osc; // RULE_02
  wire [8:0] caption_line = (mode_reg == `MODE_4) ? `LINE_PAL : `LINE_NTSC; // RULE_06

  ////////////////////////////////////////////////////////////////////////
  // Sync separation from the sliced video level (low = sync tip)
  // Separated sync is flagged at the end of the tip, not its start
  reg [CNT_W-1:0] low_cnt_reg;
  reg sep_hsync_reg, vsync_reg;

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      low_cnt_reg <= {CNT_W{1'b0}};
      sep_hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
    end else begin
      sep_hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      if (!video_s[1]) begin
        if (low_cnt_reg != {CNT_W{1'b1}})
          low_cnt_reg <= low_cnt_reg + 1'b1;
        // Broad pulse: flag once per low period
        if (low_cnt_reg == `VSYNC_MIN_CYC)
          vsync_reg <= 1'b1;
      end else begin
        low_cnt_reg <= {CNT_W{1'b0}};
        if (!video_d && low_cnt_reg >= `HSYNC_MIN_CYC && low_cnt_reg < `VSYNC_MIN_CYC)
          sep_hsync_reg <= 1'b1; // RULE_03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line reference by mode
  reg [4:0] osc_div_reg;
  reg osc_tick_reg;

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      osc_div_reg <= 5'h00;
      osc_tick_reg <= 1'b0;
    end else begin
      osc_tick_reg <= 1'b0;
      if (mode_osc && rises(hpin_d, hpin_s[1])) begin
        osc_div_reg <= osc_div_reg + 5'h01;
        if (osc_div_reg == `OSC_DIV)
          osc_tick_reg <= 1'b1; // RULE_04
      end
    end
  end

  wire ext_hsync = falls(hpin_d, hpin_s[1]); // Active-low sync, leading edge
  reg raw_tick;
  always @* begin
    case (mode_reg)
      `MODE_1: raw_tick = sep_hsync_reg; // RULE_03
      `MODE_2: raw_tick = osc_tick_reg; // RULE_04
      default: raw_tick = ext_hsync; // RULE_05 RULE_06
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Line counter and field parity
  // Holdoff masks equalising pulses at half-line spacing
  reg [CNT_W-1:0] since_line_reg;
  reg [8:0] line_reg;
  reg even_field_reg;
  wire line_tick = raw_tick && (since_line_reg >= `LINE_HOLD_CYC);

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      since_line_reg <= {CNT_W{1'b0}};
      // Line number unknown until the first vertical sync
      line_reg <= 9'h1FF;
      even_field_reg <= 1'b0;
    end else begin
      if (line_tick)
        since_line_reg <= {CNT_W{1'b0}};
      else if (since_line_reg != {CNT_W{1'b1}})
        since_line_reg <= since_line_reg + 1'b1;
      // Vertical sync landing mid-line marks the even field
      if (vsync_reg && line_reg > 9'h008) begin
        line_reg <= `LINE_AFTER_VSYNC;
        even_field_reg <= (since_line_reg >= `HALF_LINE_CYC);
      end else if (line_tick && line_reg != 9'h1FF) begin
        line_reg <= line_reg + 9'h001;
      end
    end
  end

  // Judged at the tick that starts the next line, hence one line early
  wire at_caption_line = (line_reg == caption_line - 9'h001) && (even_field_reg || !mode_even_only);

  ////////////////////////////////////////////////////////////////////////
  // Caption sampling on the selected line
  reg [CNT_W-1:0] bit_timer_reg;
  reg [4:0] bit_cnt_reg;
  reg sampling_reg;
  reg [DATA_W-1:0] cap_shift_reg;
  reg cap_valid_reg;
  wire buf_ready;

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      bit_timer_reg <= {CNT_W{1'b0}};
      bit_cnt_reg <= 5'h00;
      sampling_reg <= 1'b0;
      cap_shift_reg <= {DATA_W{1'b0}};
      cap_valid_reg <= 1'b0;
    end else begin
      if (cap_valid_reg && buf_ready)
        cap_valid_reg <= 1'b0;
      if (line_tick) begin
        sampling_reg <= at_caption_line; // RULE_02 RULE_05 RULE_06
        bit_timer_reg <= FIRST_BIT_C;
        bit_cnt_reg <= 5'h00;
      end else if (sampling_reg) begin
        if (bit_timer_reg != {CNT_W{1'b0}}) begin
          bit_timer_reg <= bit_timer_reg - 1'b1;
        end else begin
          // LSB arrives first on the line
          cap_shift_reg <= {video_s[1], cap_shift_reg[DATA_W-1:1]};
          bit_timer_reg <= BIT_PERIOD_C;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == `CAPTION_BITS - 5'h01) begin
            sampling_reg <= 1'b0;
            // A word still waiting is replaced by the newer one
            cap_valid_reg <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  reg [DATA_W-1:0] buf_mem [0:1];
  reg buf_wp_reg, buf_rp_reg;
  reg [1:0] buf_cnt_reg;
  assign buf_ready = (buf_cnt_reg != 2'h2);
  wire buf_valid = (buf_cnt_reg != 2'h0);
  wire buf_push = cap_valid_reg && buf_ready;
  reg sel_d_reg;
  wire cs_fall = falls(sel_d_reg, cs_s[1]);
  wire buf_pop = cs_fall && buf_valid;

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp_reg] <= cap_shift_reg;
        buf_wp_reg <= ~buf_wp_reg;
      end
      if (buf_pop)
        buf_rp_reg <= ~buf_rp_reg;
      if (buf_push && !buf_pop)
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      else if (buf_pop && !buf_push)
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial transfer under the decoder's clock
  reg [DATA_W-1:0] tx_shift_reg;
  wire sck_fall = falls(sck_d, sck_s[1]);
  // Released line reads as one through the pull-up

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      sel_d_reg <= 1'b1;
      tx_shift_reg <= `EMPTY_WORD;
      CAPTION_BIT_OUT <= 1'b0;
      CAPTION_BIT_OE <= 1'b0;
    end else begin
      sel_d_reg <= cs_s[1];
      CAPTION_BIT_OUT <= 1'b0; // RULE_10
      if (cs_s[1]) begin
        CAPTION_BIT_OE <= 1'b0; // RULE_16
      end else if (cs_fall) begin
        tx_shift_reg <= buf_valid ? buf_mem[buf_rp_reg] : `EMPTY_WORD;
        CAPTION_BIT_OE <= buf_valid ? !buf_mem[buf_rp_reg][0] : 1'b0; // RULE_10
      end else if (sck_fall) begin
        // Next bit after each falling transfer clock edge
        tx_shift_reg <= {1'b1, tx_shift_reg[DATA_W-1:1]}; // RULE_11 RULE_12
        CAPTION_BIT_OE <= !tx_shift_reg[1]; // RULE_10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode-dependent pins
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      LINE_PULSE_OUT <= 1'b0;
      FIELD_PARITY_OUT <= 1'b0;
      HORIZ_SYNC_OUT <= 1'b1;
      HORIZ_SYNC_OE <= 1'b0;
    end else begin
      if (line_tick)
        LINE_PULSE_OUT <= at_caption_line; // RULE_07
      // Oscillator feedback is an inverter here; a real part uses an analog stage
      if (mode_osc)
        FIELD_PARITY_OUT <= !hpin_s[1]; // RULE_08
      else
        FIELD_PARITY_OUT <= !even_field_reg; // RULE_08
      HORIZ_SYNC_OE <= (mode_reg == `MODE_1); // RULE_09
      HORIZ_SYNC_OUT <= video_s[1]; // RULE_09
    end
  end

endmodule

// File: rtl/caption_map.vh
`ifndef CAPTION_MAP_VH
`define CAPTION_MAP_VH

// Clock and derived counts
`define CLK_PERIOD_NS 40
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)

// Mode codes, {strap_high, strap_low}
`define MODE_1 2'h0
`define MODE_2 2'h1
`define MODE_3 2'h2
`define MODE_4 2'h3

// Caption line numbers
`define LINE_NTSC 9'h015
`define LINE_PAL 9'h016
`define LINE_AFTER_VSYNC 9'h004

// Reference divider for the oscillator mode
`define OSC_DIV 5'h1F

// Sync separation times
`define HSYNC_MIN_NS 2000
`define HSYNC_MIN_CYC `CYC_UP(`HSYNC_MIN_NS)
`define VSYNC_MIN_NS 10000
`define VSYNC_MIN_CYC `CYC_UP(`VSYNC_MIN_NS)
`define HALF_LINE_NS 31750
`define HALF_LINE_CYC `CYC_DN(`HALF_LINE_NS)
`define LINE_HOLD_NS 40000
`define LINE_HOLD_CYC `CYC_UP(`LINE_HOLD_NS)

// Caption bit sampling
`define FIRST_BIT_NS 30000
`define FIRST_BIT_CYC `CYC_DN(`FIRST_BIT_NS)
`define BIT_PERIOD_NS 1986
`define BIT_PERIOD_CYC `CYC_DN(`BIT_PERIOD_NS)
`define CAPTION_BITS 5'h10

// Word sent when the buffer holds nothing: line stays released
`define EMPTY_WORD 16'hFFFF

`endif

// File: verif/caption_asserts.sv
`timescale 1ns/100ps
module caption_asserts (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire MODE_STRAP_LOW,
  input wire MODE_STRAP_HIGH,
  input wire COMPOSITE_VIDEO_IN,
  input wire HORIZ_SYNC_OR_OSC_IN,
  input wire HORIZ_SYNC_OUT,
  input wire HORIZ_SYNC_OE,
  input wire LINE_PULSE_OUT,
  input wire FIELD_PARITY_OUT,
  input wire TRANSFER_CLOCK_IN,
  input wire CHIP_SELECT_N,
  input wire CAPTION_BIT_OUT,
  input wire CAPTION_BIT_OE
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  wire m1 = !MODE_STRAP_HIGH && !MODE_STRAP_LOW;
  wire m2 = !MODE_STRAP_HIGH && MODE_STRAP_LOW;
  //////////////////////////////////////////////////////////////////////////
  // Five- and six-cycle windows absorb the two-flop input synchronisers
  property p_od; CAPTION_BIT_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin high");
  property p_desel; CHIP_SELECT_N [*5] |-> !CAPTION_BIT_OE; endproperty
  a_desel: assert property (p_desel) else $error("pulled unselected");
  property p_hs_on; m1 [*6] |-> HORIZ_SYNC_OE; endproperty
  a_hs_on: assert property (p_hs_on) else $error("sync out off");
  property p_hs_off; !m1 [*6] |-> !HORIZ_SYNC_OE; endproperty
  a_hs_off: assert property (p_hs_off) else $error("sync pin driven");
  property p_copy; (m1 && $stable(COMPOSITE_VIDEO_IN)) [*6]
    |-> HORIZ_SYNC_OUT == COMPOSITE_VIDEO_IN; endproperty
  a_copy: assert property (p_copy) else $error("sync copy wrong");
  property p_osc; (m2 && $stable(HORIZ_SYNC_OR_OSC_IN)) [*6]
    |-> FIELD_PARITY_OUT != HORIZ_SYNC_OR_OSC_IN; endproperty
  a_osc: assert property (p_osc) else $error("osc out wrong");
  property p_hold; (!CHIP_SELECT_N && $stable(TRANSFER_CLOCK_IN)) [*6]
    |-> $stable(CAPTION_BIT_OE); endproperty
  a_hold: assert property (p_hold) else $error("shift without clock");
  property p_pulse; $rose(LINE_PULSE_OUT) |=> LINE_PULSE_OUT [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too short");
endmodule
bind caption_line_extractor caption_asserts chk (.SYS_CLK, .RESET_N, .MODE_STRAP_LOW,
  .MODE_STRAP_HIGH, .COMPOSITE_VIDEO_IN, .HORIZ_SYNC_OR_OSC_IN, .HORIZ_SYNC_OUT,
  .HORIZ_SYNC_OE, .LINE_PULSE_OUT, .FIELD_PARITY_OUT, .TRANSFER_CLOCK_IN, .CHIP_SELECT_N,
  .CAPTION_BIT_OUT, .CAPTION_BIT_OE);

// File: verif/caption_decoder_model.sv
`timescale 1ns/100ps
module caption_decoder_model (
  input wire data_line,
  output reg sck = 1'b1,
  output reg cs_n = 1'b1
);
  //////////////////////////////////////////////////////////////////////////
  // Clock rests high between frames; slow triples the clock half-periods, not the select gaps
  task read_word(input bit slow, output logic [15:0] w);
    int i;
    int h;
    h = slow ? 480 : 160;
    cs_n = 1'b0;
    #1000;
    w[0] = data_line;
    for (i = 1; i <= 16; i++) begin
      sck = 1'b0;
      #h;
      sck = 1'b1;
      #h;
      if (i < 16) w[i] = data_line;
    end
    cs_n = 1'b1;
    #1000;
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "caption_map.vh"
module tb_top;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg s_lo = 1'b0;
  reg s_hi = 1'b0;
  reg video = 1'b1;
  reg hs = 1'b1;
  wire hs_out, hs_oe, lp, par, sck, cs_n, bit_out, bit_oe;
  wire hs_pin = hs_oe ? hs_out : hs;
  wire line = bit_oe ? bit_out : 1'b1;
  int miscompares = 0;
  int tests_run = 0;
  int cyc;
  int r;
  logic [15:0] w;
  // Row: strap high, strap low, pin, video, sync enable
  logic [4:0] rows [4] = '{5'b00101, 5'b01010, 5'b10110, 5'b11110};
  always #20 sys_clk = ~sys_clk;
  caption_line_extractor dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .MODE_STRAP_LOW(s_lo),
    .MODE_STRAP_HIGH(s_hi), .COMPOSITE_VIDEO_IN(video), .HORIZ_SYNC_OR_OSC_IN(hs_pin),
    .HORIZ_SYNC_OUT(hs_out), .HORIZ_SYNC_OE(hs_oe), .LINE_PULSE_OUT(lp),
    .FIELD_PARITY_OUT(par), .TRANSFER_CLOCK_IN(sck), .CHIP_SELECT_N(cs_n),
    .CAPTION_BIT_OUT(bit_out), .CAPTION_BIT_OE(bit_oe));
  caption_decoder_model dec (.data_line(line), .sck(sck), .cs_n(cs_n));
  //////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task upto(input int c);
    cycles(c - cyc);
    cyc = c;
  endtask
  // Bit cells of 1986 ns, centred on the sample points from 30 us
  task vline(input int kind, input logic [15:0] pat);
    int i;
    cyc = 0;
    hs = 1'b0;
    upto(125);
    hs = 1'b1;
    if (kind == 0) begin
      upto(600);
      check("no pulse", 16'(lp), 16'h0000);
    end
    if (kind == 1) begin
      upto(500);
      video = 1'b0;
      upto(875);
      video = 1'b1;
    end
    if (kind == 2) begin
      upto(600);
      check("line pulse", 16'(lp), 16'h0001);
      for (i = 0; i <= 16; i++) begin
        upto((29007 + i * 1986) / 40);
        video = (i < 16) ? pat[i] : 1'b1;
      end
    end
    upto(1587);
  endtask
  task frame(input int cap, input logic [15:0] pat);
    int n;
    vline(0, pat);
    vline(1, pat);
    for (n = 5; n <= cap + 1; n++) vline((n == cap) ? 2 : 0, pat);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(3);
    check("pulse in reset", 16'(lp), 16'h0000);
    check("data in reset", 16'(bit_oe), 16'h0000);
    cycles(1);
    reset_n = 1'b1;
    cycles(4);
    for (r = 0; r < 4; r++) begin
      {s_hi, s_lo, hs, video} = rows[r][4:1];
      cycles(10);
      check("sync enable", 16'(hs_oe), 16'(rows[r][0]));
      if (r == 0) check("sync copy", 16'(hs_out), 16'h0000);
      if (r == 1) check("osc out", 16'(par), 16'h0001);
    end
    video = 1'b1;
    dec.read_word(1'b0, w);
    check("empty", w, `EMPTY_WORD);
    {s_hi, s_lo} = `MODE_3;
    cycles(8);
    frame(21, 16'hA5C3);
    check("field parity", 16'(par), 16'h0001);
    {s_hi, s_lo} = `MODE_4;
    cycles(8);
    // Both words wait in the buffer until the decoder reads
    frame(22, 16'h5AB6);
    dec.read_word(1'b1, w);
    check("first word", w, 16'hA5C3);
    dec.read_word(1'b0, w);
    check("second word", w, 16'h5AB6);
    dec.read_word(1'b0, w);
    check("drained", w, `EMPTY_WORD);
    close_out;
  end
  initial begin
    #4000000;
    miscompares++;
    close_out;
  end
endmodule
